// ---- rtl/vdpc_pkg.sv ----
// constants and carrier types for the decoder processing control bank
package vdpc_pkg;
    localparam logic [7:0] ADDR_CHROMA = 8'h03;
    localparam logic [7:0] ADDR_BURST  = 8'h04;
    localparam logic [7:0] ADDR_PED    = 8'h05;
    localparam logic [7:0] ADDR_LUMA   = 8'h06;
    localparam logic [7:0] ADDR_COMB   = 8'h07;
    localparam logic [7:0] ADDR_CLAMP  = 8'h08;
    localparam logic [7:0] ADDR_STD    = 8'h09;
    localparam logic [7:0] ADDR_OFMT   = 8'h0A;
    localparam logic [7:0] ADDR_OMUX   = 8'h0B;
    localparam logic [7:0] ADDR_COMB_ADAPTION_MODE  = 8'h0C;
    localparam logic [7:0] RESET_VAL   = 8'h00;
    localparam logic [1:0] CLAMP_OFF240 = 2'h0;
    localparam logic [1:0] CLAMP_OFF256 = 2'h1;
    localparam logic [1:0] CLAMP_VIDB   = 2'h2;
    localparam logic [9:0] BLACK_240    = 10'h0F0;
    localparam logic [9:0] BLACK_256    = 10'h100;
    localparam logic [3:0] STD_NTSC_M   = 4'h0;
    localparam logic [3:0] STD_NTSC_J   = 4'h1;
    localparam logic [3:0] STD_PAL_BGHI = 4'h8;
    localparam logic [3:0] STD_PAL_M    = 4'h9;
    localparam logic [3:0] STD_PAL_NA   = 4'hA;
    localparam logic [3:0] STD_PAL_NJ   = 4'hB;
    localparam logic [1:0] COMB_ADAPTION_MODE_BEST3  = 2'h0;
    // notch path choices
    typedef enum logic [2:0] {
        VDPC_NOTCH_ANF1, VDPC_NOTCH_ANF2, VDPC_NOTCH_ANF3,
        VDPC_NOTCH_FIXED, VDPC_NOTCH_FLAT
    } vdpc_notch_t;
    typedef struct packed {
        logic       gauss_response_select;
        logic [7:0] setup_level;
        logic       notch_rounding;
        vdpc_notch_t notch_mode;
        logic       first_linestore_source;
        logic       second_linestore_span;
        logic       bandsplit_response_select;
        logic       bandsplit_sign_invert;
        logic       extraction_line_delay;
        logic       clamp_enable;
        logic       clamp_use_second_input;
        logic [9:0] black_level;
        logic [1:0] sync_level_lsbs;
        logic [3:0] standard_select;
        logic       standard_valid;
        logic [1:0] mixed_sync_format;
        logic       chroma_out_sign_invert;
        logic       luma_limit_chroma_kill;
        logic       colour_diff_multiplex;
        logic       colour_diff_decimate;
        logic       serial_digital_out_on;
        logic       embedded_signal_out_on;
        logic       embedded_signal_rate;
        logic [1:0] comb_adaption_mode;
        logic       comb_adaption_mode_best_of_three;
    } vdpc_cfg_t;
endpackage

// ---- rtl/vdpc_regs.sv ----
// register bank steering the decoder processing chain
`timescale 1ns/1ps
module vdpc_regs #(
    parameter bit LATEST_REV = 1'b1
) (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic [7:0]           addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    input  wire logic [1:0]           comb_special_function,
    output vdpc_pkg::vdpc_cfg_t       cfg,
    output logic [7:0]                rdata
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] regs_q [3:12];
    logic [7:0] rdata_q;
    vdpc_pkg::vdpc_cfg_t cfg_q;
    vdpc_pkg::vdpc_cfg_t cfg_d;
    wire        hit = (addr >= vdpc_pkg::ADDR_CHROMA)
                   && (addr <= vdpc_pkg::ADDR_COMB_ADAPTION_MODE);
    wire [3:0]  idx = addr[3:0];
    wire [7:0]  rd_val = hit ? regs_q[idx] : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 3; i <= 12; i++) begin
                regs_q[i] <= vdpc_pkg::RESET_VAL;
            end
        end else if (wr && hit) begin
            regs_q[idx] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rd_val : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire [7:0] r3 = regs_q[3];
    wire [7:0] r6 = regs_q[6];
    wire [7:0] r7 = regs_q[7];
    wire [7:0] r8 = regs_q[8];
    wire [7:0] r9 = regs_q[9];
    wire [7:0] ra = regs_q[10];
    wire [7:0] rb = regs_q[11];
    wire [7:0] rc = regs_q[12];
    wire [1:0] clamp_code = r8[1:0];
    wire       std_ok = (r9[3:0] == vdpc_pkg::STD_NTSC_M)
                     || (r9[3:0] == vdpc_pkg::STD_NTSC_J)
                     || (r9[3:0] == vdpc_pkg::STD_PAL_BGHI)
                     || (r9[3:0] == vdpc_pkg::STD_PAL_M)
                     || (r9[3:0] == vdpc_pkg::STD_PAL_NA)
                     || (r9[3:0] == vdpc_pkg::STD_PAL_NJ);
    // special function 1x makes luma flat, which beats the notch bit
    wire       xsf_flat = comb_special_function[1];
    vdpc_pkg::vdpc_notch_t notch_sel;
    assign notch_sel = xsf_flat ? vdpc_pkg::VDPC_NOTCH_FLAT
        : r6[0] ? (r6[5] ? vdpc_pkg::VDPC_NOTCH_ANF3
                         : vdpc_pkg::VDPC_NOTCH_FIXED)
        : r6[1] ? vdpc_pkg::VDPC_NOTCH_ANF2
                : vdpc_pkg::VDPC_NOTCH_ANF1;

    always_comb begin
        cfg_d = '0;
        cfg_d.gauss_response_select     = r3[0];
        cfg_d.setup_level               = regs_q[5];
        cfg_d.notch_rounding            = r6[4];
        cfg_d.notch_mode                = notch_sel;
        cfg_d.first_linestore_source    = r7[6];
        cfg_d.second_linestore_span     = r7[5];
        cfg_d.bandsplit_response_select = r7[2];
        cfg_d.bandsplit_sign_invert     = r7[1];
        cfg_d.extraction_line_delay     = r7[0];
        // older silicon reuses the clamp bits as sync level lsbs
        cfg_d.clamp_enable = LATEST_REV && clamp_code[1];
        cfg_d.clamp_use_second_input = LATEST_REV
            && (clamp_code == vdpc_pkg::CLAMP_VIDB);
        cfg_d.black_level = (LATEST_REV
            && clamp_code == vdpc_pkg::CLAMP_OFF256)
            ? vdpc_pkg::BLACK_256 : vdpc_pkg::BLACK_240;
        cfg_d.sync_level_lsbs = LATEST_REV ? 2'h0 : clamp_code;
        cfg_d.standard_select        = r9[3:0];
        cfg_d.standard_valid         = std_ok;
        cfg_d.mixed_sync_format      = ra[4:3];
        cfg_d.chroma_out_sign_invert = ra[2];
        cfg_d.luma_limit_chroma_kill = ra[1];
        cfg_d.colour_diff_multiplex  = rb[7];
        cfg_d.colour_diff_decimate   = rb[6];
        cfg_d.serial_digital_out_on  = rb[5];
        cfg_d.embedded_signal_out_on = rb[1];
        cfg_d.embedded_signal_rate   = rb[0];
        cfg_d.comb_adaption_mode     = rc[7:6];
        cfg_d.comb_adaption_mode_best_of_three =
            (rc[7:6] == vdpc_pkg::COMB_ADAPTION_MODE_BEST3);
    end

    // one flop after storage: fields reach the path one cycle after write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg   = cfg_q;
    assign rdata = rdata_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_store(logic [7:0] a);
        wr && addr == a;
    endsequence

    sequence s_fetch_mapped;
        rd && hit;
    endsequence

    sequence s_quiet_regs;
        !wr ##1 $stable(comb_special_function);
    endsequence

    // write lands in storage, then one more flop before the path sees it
    a_write_reaches_cfg: assert property (
        @(posedge clk) disable iff (!resetn)
        s_store(vdpc_pkg::ADDR_PED) |=> ##1 cfg.setup_level == $past(wdata, 2)
    )
    else $error("setup level not applied");

    a_read_data_next: assert property (
        @(posedge clk) disable iff (!resetn)
        rd && !hit |=> rdata == 8'h00
    )
    else $error("unmapped read");

    a_read_returns: assert property (
        @(posedge clk) disable iff (!resetn)
        s_fetch_mapped |=> rdata == $past(rd_val)
    )
    else $error("read data wrong");

    a_read_idle: assert property (
        @(posedge clk) disable iff (!resetn)
        !rd |=> rdata == 8'h00
    )
    else $error("read data outside slot");

    a_cfg_hold: assert property (
        @(posedge clk) disable iff (!resetn)
        s_quiet_regs |=> $stable(cfg)
    )
    else $error("cfg moved without write");

    a_gauss_follow: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.gauss_response_select == $past(r3[0])
    )
    else $error("gauss select wrong");

    a_rounding_follow: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.notch_rounding == $past(r6[4])
    )
    else $error("notch rounding wrong");

    a_notch_anf1: assert property (
        @(posedge clk) disable iff (!resetn)
        !r6[0] && !r6[1] && !xsf_flat |=> cfg.notch_mode == '0
    )
    else $error("notch one wrong");

    a_notch_anf2: assert property (
        @(posedge clk) disable iff (!resetn)
        !r6[0] && r6[1] && !xsf_flat |=> cfg.notch_mode == 3'h1
    )
    else $error("notch two wrong");

    a_notch_anf3: assert property (
        @(posedge clk) disable iff (!resetn)
        r6[0] && r6[5] && !xsf_flat |=> cfg.notch_mode == 3'h2
    )
    else $error("notch three wrong");

    a_notch_fixed: assert property (
        @(posedge clk) disable iff (!resetn)
        r6[0] && !r6[5] && !xsf_flat |=> cfg.notch_mode == 3'h3
    )
    else $error("fixed notch wrong");

    a_notch_flat: assert property (
        @(posedge clk) disable iff (!resetn)
        xsf_flat |=> cfg.notch_mode == 3'h4
    )
    else $error("flat luma override wrong");

    a_linestore_src: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.first_linestore_source == $past(r7[6])
    )
    else $error("linestore source wrong");

    a_linestore_span: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.second_linestore_span == $past(r7[5])
    )
    else $error("linestore span wrong");

    a_bandsplit_resp: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.bandsplit_response_select == $past(r7[2])
    )
    else $error("bandsplit response wrong");

    a_bandsplit_sign: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.bandsplit_sign_invert == $past(r7[1])
    )
    else $error("bandsplit sign wrong");

    a_extract_delay: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.extraction_line_delay == $past(r7[0])
    )
    else $error("extraction delay wrong");

    a_clamp_black: assert property (
        @(posedge clk) disable iff (!resetn)
        LATEST_REV && clamp_code == vdpc_pkg::CLAMP_OFF240 |=>
        cfg.black_level == vdpc_pkg::BLACK_240 && !cfg.clamp_enable)
    else $error("clamp black level wrong");

    a_clamp_black256: assert property (
        @(posedge clk) disable iff (!resetn)
        LATEST_REV && clamp_code == vdpc_pkg::CLAMP_OFF256 |=>
        cfg.black_level == vdpc_pkg::BLACK_256 && !cfg.clamp_enable)
    else $error("clamp black 256 wrong");

    a_clamp_vidb: assert property (
        @(posedge clk) disable iff (!resetn)
        LATEST_REV && clamp_code == vdpc_pkg::CLAMP_VIDB |=>
        cfg.clamp_enable && cfg.clamp_use_second_input)
    else $error("clamp second input wrong");

    a_clamp_internal: assert property (
        @(posedge clk) disable iff (!resetn)
        LATEST_REV && clamp_code == 2'h3 |=>
        cfg.clamp_enable && !cfg.clamp_use_second_input)
    else $error("clamp internal wrong");

    a_sync_lsbs: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.sync_level_lsbs == (LATEST_REV ? 2'h0 : $past(clamp_code))
    )
    else $error("sync level lsbs wrong");

    a_old_rev_clamp: assert property (
        @(posedge clk) disable iff (!resetn)
        !LATEST_REV |=> !cfg.clamp_enable
    )
    else $error("old revision clamp active");

    a_std_follow: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.standard_select == $past(r9[3:0])
    )
    else $error("standard select wrong");

    a_std_legal: assert property (
        @(posedge clk) disable iff (!resetn)
        r9[3:0] == vdpc_pkg::STD_PAL_NJ |=> cfg.standard_valid
    )
    else $error("legal standard refused");

    a_std_reserved: assert property (
        @(posedge clk) disable iff (!resetn)
        r9[3:0] == 4'h2 |=> !cfg.standard_valid
    )
    else $error("reserved standard accepted");

    a_std_top: assert property (
        @(posedge clk) disable iff (!resetn)
        r9[3:0] == 4'hF |=> !cfg.standard_valid
    )
    else $error("top standard accepted");

    a_chroma_sign: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.chroma_out_sign_invert == $past(ra[2])
    )
    else $error("chroma sign wrong");

    a_luma_kill: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.luma_limit_chroma_kill == $past(ra[1])
    )
    else $error("luma kill wrong");

    a_mux_bit: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(rb[7]) |=> cfg.colour_diff_multiplex
    )
    else $error("multiplex late");

    a_mux_follow: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.colour_diff_multiplex == $past(rb[7])
    )
    else $error("multiplex wrong");

    a_decimate: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.colour_diff_decimate == $past(rb[6])
    )
    else $error("decimate wrong");

    a_serial_out: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.serial_digital_out_on == $past(rb[5])
    )
    else $error("serial output wrong");

    a_embed_on: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.embedded_signal_out_on == $past(rb[1])
    )
    else $error("embedded enable wrong");

    a_embed_rate: assert property (
        @(posedge clk) disable iff (!resetn)
        1'b1 |=> cfg.embedded_signal_rate == $past(rb[0])
    )
    else $error("embedded rate wrong");

    a_comb_adaption_mode_best: assert property (
        @(posedge clk) disable iff (!resetn)
        rc[7:6] == 2'h1 |=> !cfg.comb_adaption_mode_best_of_three
    )
    else $error("adaption code wrong");

    a_comb_adaption_mode_zero: assert property (
        @(posedge clk) disable iff (!resetn)
        rc[7:6] == vdpc_pkg::COMB_ADAPTION_MODE_BEST3 |=> cfg.comb_adaption_mode_best_of_three
    )
    else $error("best of three missing");
endmodule

// ---- verif/video_decoder_processing_control_bench.sv ----
// self-checking bench for the decoder processing control bank
`timescale 1ns/1ps
module video_decoder_processing_control_bench;
    logic                clk;
    logic                resetn;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic                wr;
    logic                rd;
    logic [1:0]          comb_special_function;
    vdpc_pkg::vdpc_cfg_t cfg;
    logic [7:0]          rdata;
    int                  n_errors;
    int                  n_tests;
    int                  i;
    wire  [4:0]          comb_f;
    wire  [4:0]          omux_f;
    assign comb_f = {cfg.first_linestore_source, cfg.second_linestore_span,
        cfg.bandsplit_response_select, cfg.bandsplit_sign_invert,
        cfg.extraction_line_delay};
    assign omux_f = {cfg.colour_diff_multiplex, cfg.colour_diff_decimate,
        cfg.serial_digital_out_on, cfg.embedded_signal_out_on,
        cfg.embedded_signal_rate};

    vdpc_regs u_vdpc_regs (.clk(clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd),
        .comb_special_function(comb_special_function),
        .cfg(cfg), .rdata(rdata));

    // ------------------------------------------------------------
    // clock, access tasks, verdict
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [9:0] seen,
                       input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // returns once the cfg flop has taken the written value
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic r(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", {2'h0, rdata}, {2'h0, exp});
        @(posedge clk);
        #1;
        chk("rdata idle", {2'h0, rdata}, 10'h000);
    endtask

    task automatic report_and_stop;
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // run is well under 1000 cycles; 4000 means a hang
    initial begin
        #20000;
        n_errors++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        comb_special_function = 2'h0;
        n_errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        chk("black", cfg.black_level, vdpc_pkg::BLACK_240);
        // unmapped 0x02 and 0x0D must neither store nor read back
        for (i = 2; i <= 13; i++) begin
            r(i[7:0], 8'h00);
            w(i[7:0], 8'hA0 + i[7:0]);
            r(i[7:0], (i inside {2, 13}) ? 8'h00 : 8'hA0 + i[7:0]);
        end
        w(vdpc_pkg::ADDR_CHROMA, 8'h01);
        chk("gauss", cfg.gauss_response_select, 10'h001);
        w(vdpc_pkg::ADDR_PED, 8'h5A);
        chk("setup", cfg.setup_level, 10'h05A);
        w(vdpc_pkg::ADDR_LUMA, 8'h10);
        chk("rnd", {cfg.notch_rounding, cfg.notch_mode}, 10'h008);
        w(vdpc_pkg::ADDR_LUMA, 8'h02);
        chk("notch", cfg.notch_mode, vdpc_pkg::VDPC_NOTCH_ANF2);
        w(vdpc_pkg::ADDR_LUMA, 8'h21);
        chk("notch", cfg.notch_mode, vdpc_pkg::VDPC_NOTCH_ANF3);
        w(vdpc_pkg::ADDR_LUMA, 8'h01);
        chk("notch", cfg.notch_mode, vdpc_pkg::VDPC_NOTCH_FIXED);
        @(posedge clk);
        comb_special_function <= 2'h2;
        w(vdpc_pkg::ADDR_LUMA, 8'h21);
        chk("notch", cfg.notch_mode, vdpc_pkg::VDPC_NOTCH_FLAT);
        @(posedge clk);
        comb_special_function <= 2'h0;
        w(vdpc_pkg::ADDR_COMB, 8'h45);
        chk("comb", comb_f, 10'h015);
        w(vdpc_pkg::ADDR_COMB, 8'h22);
        chk("comb", comb_f, 10'h00A);
        for (i = 0; i < 4; i++) begin
            w(vdpc_pkg::ADDR_CLAMP, i[7:0]);
            chk("clamp", {cfg.clamp_enable, cfg.clamp_use_second_input},
                {i[1], i == 2});
            chk("sync lsb", cfg.sync_level_lsbs, 10'h000);
            if (i < 2) begin
                chk("black", cfg.black_level, (i == 0) ?
                    vdpc_pkg::BLACK_240 : vdpc_pkg::BLACK_256);
            end
        end
        for (i = 0; i < 16; i++) begin
            w(vdpc_pkg::ADDR_STD, i[7:0]);
            chk("std", {cfg.standard_valid, cfg.standard_select},
                {i inside {0, 1, 8, 9, 10, 11}, i[3:0]});
        end
        w(vdpc_pkg::ADDR_OFMT, 8'h14);
        chk("ofmt", {cfg.mixed_sync_format, cfg.chroma_out_sign_invert,
            cfg.luma_limit_chroma_kill}, 10'h00A);
        w(vdpc_pkg::ADDR_OFMT, 8'h0A);
        chk("ofmt", {cfg.mixed_sync_format, cfg.chroma_out_sign_invert,
            cfg.luma_limit_chroma_kill}, 10'h005);
        w(vdpc_pkg::ADDR_OMUX, 8'hA1);
        chk("omux", omux_f, 10'h015);
        w(vdpc_pkg::ADDR_OMUX, 8'h42);
        chk("omux", omux_f, 10'h00A);
        for (i = 0; i < 4; i++) begin
            w(vdpc_pkg::ADDR_COMB_ADAPTION_MODE, {i[1:0], 6'h00});
            chk("comb_adaption_mode", {cfg.comb_adaption_mode_best_of_three, cfg.comb_adaption_mode},
                {i == 0, i[1:0]});
        end
        report_and_stop();
    end
endmodule
